//--- core/grfc_counter.sv
// Frequency counter core: input selector, gate and reciprocal timing, 16-bit accumulator.
// Assumes references and signal inputs are asynchronous square waves slower than 12.5 MHz.
// Function
// - Processor selects counter input: front-end signal, demod audio or offset tone.
// - Offset tone serves carrier error; demod audio serves signalling decode.
// - Direct mode counts selected input cycles in 16 bits while gate open.
// - Gate time selectable from 1 ms to 10 s by processor.
// - Every gate time is divided down from the 1 kHz reference.
// - Reciprocal mode counts reference clocks during one input period.
// - Reciprocal clock selectable from 10 MHz down to 100 kHz.
// - Reciprocal clocks are divided from the 10 MHz reference.
// - The 16-bit result is readable over the processor port.
`timescale 1ns/1ns
module grfc_counter
  import grfc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        counter_input,
  input  wire logic        calibrated_demod_audio,
  input  wire logic        carrier_offset_tone,
  input  wire logic        kilohertz_reference,
  input  wire logic        ten_megahertz_reference,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             meas_busy,
  output logic             result_ready
);
  import grfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    grfc_state_t state;
    logic [15:0] control;
    logic [15:0] accum;
    logic [15:0] result;
    logic        ready;
    logic        overflow;
    logic [13:0] gate_cnt;
    logic [6:0]  div_cnt;
    logic [15:0] rdata;
    logic        busy;
  } grfc_core_t;

  grfc_core_t st;
  grfc_core_t next_st;

  logic sig_rise;
  logic khz_rise;
  logic mhz_rise;
  logic sel_sig;

  ////////////////////////////////////////////////////////////////////////////
  // Input selector ahead of the synchroniser keeps one edge detector
  always_comb begin
    case (st.control[CTL_SRC_HI:CTL_SRC_LO])
      SRC_DEMOD:  sel_sig = calibrated_demod_audio;
      SRC_OFFSET: sel_sig = carrier_offset_tone;
      default:    sel_sig = counter_input;
    endcase
  end

  // Selected input and both references each pass three synchroniser flip-flops
  grfc_edge_sync u_sig_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (sel_sig),
    .rise     (sig_rise)
  );

  grfc_edge_sync u_khz_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (kilohertz_reference),
    .rise     (khz_rise)
  );

  // Limitation: at 50 MHz a 10 MHz reference is sampled with little margin
  grfc_edge_sync u_mhz_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in (ten_megahertz_reference),
    .rise     (mhz_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]  range_sel;
  logic [13:0] gate_len;
  logic [6:0]  div_len;
  logic        recip;
  logic        clk_tick;
  logic        wr_ctl;
  logic [16:0] acc_inc;

  always_comb begin
    range_sel = st.control[CTL_RANGE_HI:CTL_RANGE_LO];
    recip     = st.control[CTL_RECIP];
    // Codes beyond each table fall back to the longest setting
    gate_len  = GATE_TICKS[GATE_STEPS-1];
    div_len   = RECIP_DIV[RECIP_STEPS-1];
    for (int i = 0; i < GATE_STEPS; i++) begin
      if (range_sel == 3'(i)) begin
        gate_len = GATE_TICKS[i];
      end
    end
    for (int i = 0; i < RECIP_STEPS; i++) begin
      if (range_sel == 3'(i)) begin
        div_len = RECIP_DIV[i];
      end
    end
    clk_tick = mhz_rise && (st.div_cnt == div_len - 7'h01);
    // Writes to any other offset are dropped
    wr_ctl   = reg_wr && (reg_addr == REG_CONTROL);
    // One incrementer for both modes keeps the wrap and overflow rule identical
    acc_inc  = {1'b0, st.accum} + 17'h00001;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (wr_ctl) begin
      next_st.control = reg_wdata;
      next_st.control[CTL_START] = 1'b0;
    end
    if (mhz_rise) begin
      next_st.div_cnt = clk_tick ? 7'h00 : st.div_cnt + 7'h01;
    end
    case (st.state)
      ST_IDLE: begin
        // Start is honoured only here; while busy only the control fields move
        if (wr_ctl && reg_wdata[CTL_START]) begin
          next_st.accum    = 16'h0000;
          // Overflow sticks until the next start so a wrapped count is never trusted
          next_st.overflow = 1'b0;
          next_st.gate_cnt = 14'h0000;
          next_st.div_cnt  = 7'h00;
          next_st.ready    = 1'b0;
          next_st.state    = ST_ARM;
        end
      end
      ST_ARM: begin
        // Gate opens on a reference edge (direct) or input edge (reciprocal)
        if (recip ? sig_rise : khz_rise) begin
          // Divider restarts with the gate so every clock inside it is a whole one
          next_st.div_cnt = 7'h00;
          next_st.state   = ST_RUN;
        end
      end
      ST_RUN: begin
        if (recip) begin
          if (clk_tick) begin
            {next_st.overflow, next_st.accum} = acc_inc;
            next_st.overflow = next_st.overflow | st.overflow;
          end
          if (sig_rise) begin
            next_st.state = ST_DONE;
          end
        end else begin
          if (sig_rise) begin
            {next_st.overflow, next_st.accum} = acc_inc;
            next_st.overflow = next_st.overflow | st.overflow;
          end
          if (khz_rise) begin
            next_st.gate_cnt = st.gate_cnt + 14'h0001;
            if (st.gate_cnt == gate_len - 14'h0001) begin
              next_st.state = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        // Result stays put until the next measurement finishes
        next_st.result = st.accum;
        next_st.ready  = 1'b1;
        next_st.state  = ST_IDLE;
      end
      default: next_st.state = ST_IDLE;
    endcase
    next_st.busy = (next_st.state != ST_IDLE);
    //////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CONTROL: next_st.rdata = st.control;
        REG_STATUS:  next_st.rdata = {13'h0000, st.overflow, st.ready, st.busy};
        REG_RESULT: begin
          next_st.rdata = st.result;
          next_st.ready = 1'b0;
        end
        default:     next_st.rdata = 16'h0000;
      endcase
    end
    // A finishing measurement wins over a read clearing ready
    if (st.state == ST_DONE) begin
      next_st.ready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st         <= '0;
      st.state   <= ST_IDLE;
      st.control <= CONTROL_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata    = st.rdata;
  assign meas_busy    = st.busy;
  assign result_ready = st.ready;
endmodule : grfc_counter

//--- core/grfc_edge_sync.sv
// Three-stage synchroniser with rising edge detector.
// Assumes an asynchronous input and clk_sys domain.
`timescale 1ns/1ns
module grfc_edge_sync
  import grfc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      rise
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sh;
    logic                   level;
    logic                   rise;
  } grfc_sync_t;

  grfc_sync_t state;
  grfc_sync_t next_state;

  // First stage feeds only the second; a level is accepted once stages two and three agree
  always_comb begin
    next_state = state;
    next_state.sh = {state.sh[SYNC_STAGES-2:0], async_in};
    if (state.sh[1] == state.sh[2]) begin
      next_state.level = state.sh[2];
    end
    next_state.rise = next_state.level & ~state.level;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise = state.rise;
endmodule : grfc_edge_sync

//--- shared/grfc_pkg.sv
// Package for the gated reciprocal frequency counter.
// Assumes one 50 MHz system clock and a plain register port.
package grfc_pkg;

  // Register offsets on the plain port
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_RESULT  = 4'h2;

  // Control field positions
  localparam int CTL_START     = 0;
  localparam int CTL_RECIP     = 1;
  localparam int CTL_SRC_LO    = 2;
  localparam int CTL_SRC_HI    = 3;
  localparam int CTL_RANGE_LO  = 4;
  localparam int CTL_RANGE_HI  = 6;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // Input selector codes
  localparam logic [1:0] SRC_COUNTER_IN = 2'h0;
  localparam logic [1:0] SRC_DEMOD      = 2'h1;
  localparam logic [1:0] SRC_OFFSET     = 2'h2;

  // Gate decades 1 ms .. 10 s in 1 kHz reference ticks
  localparam int GATE_STEPS = 5;
  localparam int RECIP_STEPS = 3;
  localparam logic [13:0] GATE_TICKS [GATE_STEPS] =
    '{14'h0001, 14'h000a, 14'h0064, 14'h03e8, 14'h2710};
  // Reciprocal clock: 10 MHz, 1 MHz, 100 kHz as divide ratios of 10 MHz
  localparam logic [6:0] RECIP_DIV [RECIP_STEPS] = '{7'h01, 7'h0a, 7'h64};

  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN, ST_DONE} grfc_state_t;

endpackage : grfc_pkg

//--- testbench/grfc_monitor.sv
// Checker on the counter's register port and status levels.
// Assumes one clock domain and the bind below.
`timescale 1ns/1ns
module grfc_monitor
  import grfc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        meas_busy,
  input wire logic        result_ready
);
  import grfc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  property p_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata outside read slot");
  property p_unm; reg_rd && reg_addr > REG_RESULT |=> reg_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_stat;
    reg_rd && reg_addr == REG_STATUS |=> reg_rdata[1:0] == $past({result_ready, meas_busy});
  endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_start;
    reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTL_START] && !meas_busy |=> meas_busy;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  // Only a direct gate has a floor; a fast input may end a reciprocal run early
  property p_gate;
    reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTL_START] && !reg_wdata[CTL_RECIP] &&
      !meas_busy |=> meas_busy [*8];
  endproperty
  a_gate: assert property (p_gate) else $error("gate too short");
  property p_done; $rose(result_ready) |-> $fell(meas_busy); endproperty
  a_done: assert property (p_done) else $error("result without end");
  property p_hold; result_ready && !reg_rd && !reg_wr |=> result_ready; endproperty
  a_hold: assert property (p_hold) else $error("result lost unread");
  property p_clr;
    reg_rd && reg_addr == REG_RESULT && !meas_busy |=> !result_ready;
  endproperty
  a_clr: assert property (p_clr) else $error("ready not cleared");
  property p_ctl; reg_rd && reg_addr == REG_CONTROL |=> !reg_rdata[CTL_START]; endproperty
  a_ctl: assert property (p_ctl) else $error("start bit not self-clearing");
  c_done: cover property ($rose(result_ready));
  c_clr: cover property (reg_rd && reg_addr == REG_RESULT && result_ready);
  c_run: cover property ($rose(meas_busy));
endmodule : grfc_monitor

bind grfc_counter grfc_monitor u_mon (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .meas_busy, .result_ready);

//--- testbench/grfc_src_model.sv
// Far-side model: reference clocks and the three signal sources.
// Assumes free-running square waves; the kHz reference is sped up to keep runs short.
`timescale 1ns/1ns
module grfc_src_model (
  output logic kilohertz_reference,
  output logic ten_megahertz_reference,
  output logic counter_input,
  output logic calibrated_demod_audio,
  output logic carrier_offset_tone
);
  initial begin
    kilohertz_reference     = 1'b0;
    ten_megahertz_reference = 1'b0;
    counter_input           = 1'b0;
    calibrated_demod_audio  = 1'b0;
    carrier_offset_tone     = 1'b0;
  end
  // Gate ticks every 2 us instead of 1 ms
  always #1000 kilohertz_reference = ~kilohertz_reference;
  // Offset by 5 ns so reference edges never share a time step with clk_sys
  initial begin
    #5;
    forever #50 ten_megahertz_reference = ~ten_megahertz_reference;
  end
  always #100 counter_input = ~counter_input;
  always #200 calibrated_demod_audio = ~calibrated_demod_audio;
  always #1003 carrier_offset_tone = ~carrier_offset_tone;
endmodule : grfc_src_model

//--- testbench/tb_top.sv
// Bench: register tasks, a table of measurements, and a watchdog.
// Assumes the source model periods: kHz tick 2 us, inputs 200/400/2006 ns.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  import grfc_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d, r;
  logic meas_busy, result_ready, khz, tenm, cin, dem, ofs;
  int n_fail = 0, check_count = 0, k, err_khz;
  // Control words and expected counts; the offset tone period is off-grid
  logic [15:0] ctl [7] = '{16'h0001, 16'h0011, 16'h0005, 16'h0009, 16'h000b, 16'h001b, 16'h000d};
  logic [15:0] exp_c [7] = '{16'h000a, 16'h0064, 16'h0005, 16'h0001, 16'h0014, 16'h0002,
    16'h000a};
  always #10 clk_sys = ~clk_sys;
  grfc_src_model u_src (.kilohertz_reference(khz), .ten_megahertz_reference(tenm),
    .counter_input(cin), .calibrated_demod_audio(dem), .carrier_offset_tone(ofs));
  grfc_counter uut (.clk_sys, .arst_n, .counter_input(cin), .calibrated_demod_audio(dem),
    .carrier_offset_tone(ofs), .kilohertz_reference(khz), .ten_megahertz_reference(tenm),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .meas_busy, .result_ready);
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(REG_CONTROL, d); `CHK("control", CONTROL_RESET, d)
    rd(REG_STATUS, d); `CHK("status", 16'h0000, d)
    rd(REG_RESULT, d); `CHK("result", 16'h0000, d)
    rd(4'h5, d); `CHK("unmapped", 16'h0000, d)
    $display("test reset done");
    for (k = 0; k < 7; k++) begin
      wr(REG_CONTROL, ctl[k]);
      #1 `CHK("busy", 1'b1, meas_busy)
      rd(REG_CONTROL, d); `CHK("control", ctl[k] & 16'hfffe, d)
      for (int t = 0; t < 2000 && result_ready !== 1'b1; t++) @(posedge clk_sys);
      `CHK("ready", 1'b1, result_ready)
      `CHK("busy end", 1'b0, meas_busy)
      rd(REG_RESULT, r);
      d = (r > exp_c[k]) ? r - exp_c[k] : exp_c[k] - r;
      `CHK("count near", 1'b1, d <= 16'h0001)
      if (k == 4) begin
        // Offset tone at 10 MHz reference: 10000 kHz over the count, less 700 kHz nominal
        err_khz = 10000 / int'(r) - 700;
        `CHK("offset error", 1'b1, err_khz > -230 && err_khz < -170)
      end
      rd(REG_STATUS, d); `CHK("ready cleared", 16'h0000, d & 16'h0003)
      rd(REG_RESULT, d); `CHK("result held", r, d)
      $display("test measure %0d done", k);
    end
    summarize();
  end
  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule : tb_top
